// *** logic/spi_pdi_pkg.sv ***
// Shared constants and command codes for the SPI process data port
package spi_pdi_pkg;
  localparam logic [7:0] PDI_TYPE_SPI = 8'h05;
  localparam int BYTE_W = 8;
  localparam int BIT_W = 3;
  localparam int ADDR_W = 16;
  localparam int LOW_ADDR_W = 13;
  localparam int A_B0_LSB = 5;
  localparam int CMD_W = 3;
  localparam int RES_W = 2;
  localparam int IRQ_BYTES = 3;
  localparam int HDR_BYTES = 3;
  localparam int LEN_W = 8;
  localparam int POS_W = 12;
  localparam int ERR_W = 8;
  localparam logic [7:0] TERM_BYTE = 8'hFF;
  localparam logic [7:0] WAIT_BYTE = 8'hFF;
  localparam logic [7:0] FILL_BYTE = 8'h00;
  localparam logic [1:0] RES_BITS = 2'h0;
  // Configuration byte fields
  localparam int CFG_CPHA = 0;
  localparam int CFG_CPOL = 1;
  localparam int CFG_IRQ_POL = 3;
  localparam int CFG_SEL_POL = 4;
  localparam int CFG_LATE = 5;
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_READ = 3'h2,
    CMD_READ_WS = 3'h3,
    CMD_WRITE = 3'h4,
    CMD_EXT = 3'h6
  } cmd_t;
endpackage

// *** logic/spi_link_if.sv ***
// Five-wire serial link between the host end and the device end
`timescale 1ns/100ps
`default_nettype none
interface spi_link_if;
  logic slave_select;
  logic serial_clock;
  logic serial_data_in;
  logic serial_data_out;
  logic host_irq;
  modport device(
    input slave_select,
    input serial_clock,
    input serial_data_in,
    output serial_data_out,
    output host_irq
  );
  modport host(
    output slave_select,
    output serial_clock,
    output serial_data_in,
    input serial_data_out,
    input host_irq
  );
endinterface
`default_nettype wire

// *** logic/spi_pdi_device.sv ***
// Device end of the SPI process data port, with its write FIFO
//
// Contract
// - Port active only when interface type selects SPI; host_irq still follows the masked event requests while inactive
// - Mode and select/irq polarity from configuration
// - Five link signals: select, clock, in, out, irq
// - Address/command phase, then data phase
// - Address phase two or three bytes
// - Any data byte count; address increments per byte
// - Master frames bytes by select, eight clocks each
// - One bit each way per clock, full duplex
// - Sample and shift edges follow mode settings
// - MSB first; multi-byte values low byte first
// - Two-byte mode: thirteen bits, upper bits zero
// - Three-byte mode: full sixteen-bit address
// - Byte0 A12..5, byte1 A4..0 plus command
// - Byte2 A15..13, second command, two zero bits
// - Decode nop, read, read-wait, write, extension
// - Second command field uses same codes
// - Extra extension bytes accepted in address phase
// - Interrupt request bytes shifted during address phase
// - Master waits or sends one all-ones wait byte
// - All-ones byte ends read; zero bit prefetches
// - Access errors block writes, bump error counter
// - Status flag on output before first clock; mode 0/2 without late sample drives interrupt request bit 7 there instead
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Write FIFO
module data_fifo #(
  parameter int unsigned W = 24,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  logic [W-1:0] mem [DEPTH];
  logic [W-1:0] head, next_head;
  logic [AW-1:0] rp, wp, next_rp, next_wp;
  logic [AW:0] cnt, next_cnt;
  logic vld, next_vld, do_in, do_out;

  // Head word and valid are registered so the outputs leave straight from flops
  assign in_ready = (cnt != (AW + 1)'(DEPTH));
  assign out_valid = vld;
  assign out_data = head;
  assign do_in = in_valid && in_ready;
  assign do_out = out_valid && out_ready;

  always_comb begin
    next_wp = wp;
    next_rp = rp;
    next_cnt = cnt;
    if (do_in) begin
      next_wp = (wp == LAST) ? '0 : wp + 1'b1;
    end
    if (do_out) begin
      next_rp = (rp == LAST) ? '0 : rp + 1'b1;
    end
    if (do_in && !do_out) begin
      next_cnt = cnt + 1'b1;
    end else if (do_out && !do_in) begin
      next_cnt = cnt - 1'b1;
    end
    next_vld = (next_cnt != '0);
    // A word written into the slot that becomes the head bypasses the array
    next_head = (do_in && next_rp == wp) ? in_data : mem[next_rp];
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      vld <= 1'b0;
      head <= '0;
    end else if (ce) begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
      vld <= next_vld;
      head <= next_head;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && do_in) begin
      mem[wp] <= in_data;
    end
  end
endmodule

// ==========================================================
// Device end
module spi_pdi_device (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  spi_link_if.device link,
  input wire logic [7:0] process_data_interface,
  input wire logic [7:0] spi_config,
  input wire logic [spi_pdi_pkg::IRQ_BYTES*spi_pdi_pkg::BYTE_W-1:0] application_event_request,
  input wire logic [spi_pdi_pkg::IRQ_BYTES*spi_pdi_pkg::BYTE_W-1:0] event_mask,
  output logic rd_req,
  output logic [spi_pdi_pkg::ADDR_W-1:0] rd_addr,
  input wire logic rd_ack,
  input wire logic [7:0] rd_data,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [spi_pdi_pkg::ADDR_W-1:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [spi_pdi_pkg::ERR_W-1:0] err_count,
  output logic access_error
);
  import spi_pdi_pkg::*;

  typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_WAIT, PH_DATA, PH_SKIP} phase_t;
  typedef struct packed {
    phase_t ph;
    logic sel;
    logic [BIT_W-1:0] bits;
    logic [1:0] abytes;
    logic [7:0] rx;
    logic [7:0] tx;
    logic dout;
    logic [ADDR_W-1:0] addr;
    cmd_t cmd;
    logic asked;
    logic term;
    logic dbytes;
    logic err;
    logic last_ok;
    logic [7:0] rbuf;
    logic rbuf_ok;
    logic rd_req;
    logic [ADDR_W-1:0] rd_addr;
    logic [ERR_W-1:0] errs;
    logic err_pulse;
    logic irq;
  } dev_t;
  localparam dev_t DEV_RST = '{ph: PH_IDLE, cmd: CMD_NOP, last_ok: 1'b1, default: '0};

  // ========================================================
  // Link input synchronisers: select, clock, data in
  logic [2:0] s1, s2, s3;
  logic [1:0] warm, next_warm;
  // Select and edges wait until the chain holds real pin levels, so the
  // flushed reset value never looks like a select or a clock edge
  assign next_warm = (warm == '1) ? warm : warm + 1'b1;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      warm <= '0;
    end else if (ce) begin
      s1 <= {link.slave_select, link.serial_clock, link.serial_data_in};
      s2 <= s1;
      s3 <= s2;
      warm <= next_warm;
    end
  end

  logic active, sel_act, di, rise, fall, lead, trail, sample_edge, shift_edge, preload, is_read;
  logic push, fifo_ready;
  logic [7:0] irq_tx;
  dev_t st, n;

  assign active = (process_data_interface == PDI_TYPE_SPI);
  assign sel_act = (warm == '1) && (s2[2] == spi_config[CFG_SEL_POL]);
  assign di = s2[0];
  assign rise = (warm == '1) && s2[1] && !s3[1];
  assign fall = (warm == '1) && !s2[1] && s3[1];
  assign lead = spi_config[CFG_CPOL] ? fall : rise;
  assign trail = spi_config[CFG_CPOL] ? rise : fall;
  // Late out sample moves the output change onto the sampling edge
  assign sample_edge = spi_config[CFG_CPHA] ? trail : lead;
  assign shift_edge = spi_config[CFG_LATE] ? sample_edge : (spi_config[CFG_CPHA] ? lead : trail);
  assign preload = !spi_config[CFG_CPHA] && !spi_config[CFG_LATE];
  assign is_read = (st.cmd == CMD_READ) || (st.cmd == CMD_READ_WS);
  assign irq_tx = application_event_request[BYTE_W*((st.ph == PH_ADDR) ? st.abytes : 2'h2) +: BYTE_W];

  // ========================================================
  // Access sequencer
  always_comb begin
    logic [7:0] rxb;
    logic [7:0] nb;
    logic bad;
    cmd_t c;
    rxb = '0;
    nb = '0;
    bad = 1'b0;
    c = CMD_NOP;
    n = st;
    n.err_pulse = 1'b0;
    push = 1'b0;
    if (rd_ack) begin
      n.rbuf = rd_data;
      n.rbuf_ok = 1'b1;
      n.rd_req = 1'b0;
    end
    n.irq = (((application_event_request & event_mask) != '0) == spi_config[CFG_IRQ_POL]);
    if (!active) begin
      n.ph = PH_IDLE;
      n.sel = 1'b0;
      n.dout = st.last_ok;
    end else if (sel_act && !st.sel) begin
      n.sel = 1'b1;
      n.ph = PH_ADDR;
      n.bits = '0;
      n.abytes = '0;
      n.err = 1'b0;
      n.term = 1'b0;
      n.dbytes = 1'b0;
      n.asked = 1'b0;
      n.rbuf_ok = 1'b0;
      n.addr = '0;
      n.cmd = CMD_NOP;
      // Mode 0/2 normal needs bit 7 before the first edge, so no status there
      n.dout = preload ? application_event_request[BYTE_W-1] : st.last_ok;
      n.tx = {application_event_request[BYTE_W-2:0], 1'b0};
    end else if (!sel_act && st.sel) begin
      bad = st.err || (st.bits != '0) || (is_read && st.dbytes && !st.term);
      n.sel = 1'b0;
      n.ph = PH_IDLE;
      n.last_ok = !bad;
      n.err_pulse = bad;
      if (bad && st.errs != '1) begin
        n.errs = st.errs + 1'b1;
      end
    end else if (st.sel) begin
      if (shift_edge) begin
        if (st.bits == '0) begin
          if (st.ph == PH_DATA && is_read) begin
            nb = st.rbuf;
            // A fetch landing on this edge is kept for the next byte
            n.rbuf_ok = rd_ack;
            if (!st.rbuf_ok) begin
              n.err = 1'b1;
            end
          end else begin
            nb = irq_tx;
          end
          n.dout = nb[BYTE_W-1];
          n.tx = {nb[BYTE_W-2:0], 1'b0};
        end else begin
          n.dout = st.tx[BYTE_W-1];
          n.tx = {st.tx[BYTE_W-2:0], 1'b0};
        end
      end
      if (sample_edge) begin
        rxb = {st.rx[BYTE_W-2:0], di};
        n.rx = rxb;
        n.bits = st.bits + 1'b1;
        if (st.ph == PH_DATA && is_read) begin
          if (st.term) begin
            n.err = 1'b1;
          end
          if (!di && !st.asked) begin
            n.asked = 1'b1;
            n.rd_req = 1'b1;
            n.rd_addr = st.addr + 1'b1;
          end
        end
        if (st.bits == '1) begin
          unique case (st.ph)
            PH_ADDR: begin
              if (st.abytes == 2'h0) begin
                n.addr = {st.addr[ADDR_W-1:LOW_ADDR_W], rxb, st.addr[A_B0_LSB-1:0]};
                n.abytes = 2'h1;
              end else begin
                if (st.abytes == 2'h1) begin
                  n.addr = {{(ADDR_W-LOW_ADDR_W){1'b0}}, st.addr[LOW_ADDR_W-1:A_B0_LSB],
                            rxb[BYTE_W-1:CMD_W]};
                  c = cmd_t'(rxb[CMD_W-1:0]);
                end else begin
                  n.addr = {rxb[BYTE_W-1:BYTE_W-(ADDR_W-LOW_ADDR_W)], st.addr[LOW_ADDR_W-1:0]};
                  c = cmd_t'(rxb[RES_W+CMD_W-1:RES_W]);
                end
                n.abytes = 2'h2;
                n.cmd = c;
                unique case (c)
                  CMD_EXT: n.ph = PH_ADDR;
                  CMD_READ, CMD_READ_WS: begin
                    n.ph = (c == CMD_READ_WS) ? PH_WAIT : PH_DATA;
                    n.rd_req = 1'b1;
                    n.rd_addr = n.addr;
                  end
                  CMD_WRITE: n.ph = PH_DATA;
                  default: n.ph = PH_SKIP;
                endcase
              end
            end
            PH_WAIT: n.ph = PH_DATA;
            PH_DATA: begin
              n.dbytes = 1'b1;
              n.addr = st.addr + 1'b1;
              n.asked = 1'b0;
              if (is_read) begin
                n.term = (rxb == TERM_BYTE);
              end else if (!st.err) begin
                push = 1'b1;
                if (!fifo_ready) begin
                  n.err = 1'b1;
                end
              end
            end
            default: ;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= DEV_RST;
    end else if (ce) begin
      st <= n;
    end
  end

  // Writes queue here; a full queue loses the byte and fails the access
  data_fifo #(.W(ADDR_W + BYTE_W), .DEPTH(4)) wq (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data({st.addr, n.rx}),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data({wr_addr, wr_data})
  );

  assign link.serial_data_out = st.dout;
  assign link.host_irq = st.irq;
  assign rd_req = st.rd_req;
  assign rd_addr = st.rd_addr;
  assign err_count = st.errs;
  assign access_error = st.err_pulse;
endmodule
`default_nettype wire

// *** logic/spi_pdi_host.sv ***
// Host end: SPI master issuing three-byte-address reads and writes
`timescale 1ns/100ps
`default_nettype none
module spi_pdi_host #(
  parameter int unsigned SCLK_HALF = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  spi_link_if.host link,
  input wire logic [7:0] spi_config,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [spi_pdi_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [spi_pdi_pkg::LEN_W-1:0] cmd_len,
  input wire logic [7:0] wr_data,
  output logic wr_take,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic [spi_pdi_pkg::IRQ_BYTES*spi_pdi_pkg::BYTE_W-1:0] irq_bytes,
  output logic access_ok,
  output logic irq_active
);
  import spi_pdi_pkg::*;

  localparam int DIV_W = $clog2(SCLK_HALF + 1);
  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_RUN, H_HOLD, H_GAP} hphase_t;
  typedef struct packed {
    hphase_t ph;
    logic [DIV_W-1:0] div;
    logic sclk;
    logic sel;
    logic mosi;
    logic [POS_W:0] edges;
    logic [POS_W-1:0] opos;
    logic [POS_W-1:0] ipos;
    logic [7:0] rx;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [LEN_W-1:0] len;
    logic rdy;
    logic take;
    logic rvalid;
    logic [7:0] rdata;
    logic [IRQ_BYTES*BYTE_W-1:0] irqb;
    logic ok;
    logic irq;
  } host_t;
  localparam host_t HOST_RST = '{ph: H_IDLE, rdy: 1'b1, ok: 1'b1, default: '0};

  // ========================================================
  // Synchronisers for the device's outputs
  logic [1:0] s1, s2;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1 <= '0;
      s2 <= '0;
    end else if (ce) begin
      s1 <= {link.serial_data_out, link.host_irq};
      s2 <= s1;
    end
  end

  host_t st, n;
  logic tick;
  logic [POS_W-1:0] nbytes, total;
  assign tick = (st.div == DIV_W'(SCLK_HALF - 1));
  assign nbytes = POS_W'(st.len) + (st.write ? POS_W'(HDR_BYTES) : POS_W'(HDR_BYTES + 1));
  assign total = nbytes << BIT_W;

  // Byte sent at stream position idx; always three-byte addressing
  function automatic logic [7:0] tx_byte(input logic [POS_W-1:0] idx);
    if (idx == 0) begin
      return st.addr[LOW_ADDR_W-1:A_B0_LSB];
    end else if (idx == 1) begin
      return {st.addr[A_B0_LSB-1:0], CMD_EXT};
    end else if (idx == 2) begin
      return {st.addr[ADDR_W-1:LOW_ADDR_W], (st.write ? CMD_WRITE : CMD_READ_WS), RES_BITS};
    end else if (!st.write && idx == HDR_BYTES) begin
      return WAIT_BYTE;
    end else if (st.write) begin
      return wr_data;
    end
    // Only the final read byte is all ones, which stops the prefetch
    return (idx == nbytes - 1'b1) ? TERM_BYTE : FILL_BYTE;
  endfunction

  // ========================================================
  // Transfer sequencer
  always_comb begin
    logic [7:0] b;
    logic lead;
    logic [7:0] rxb;
    b = '0;
    lead = 1'b0;
    rxb = '0;
    n = st;
    n.take = 1'b0;
    n.rvalid = 1'b0;
    n.irq = (s2[0] == spi_config[CFG_IRQ_POL]);
    n.div = (st.ph == H_IDLE || tick) ? '0 : st.div + 1'b1;
    unique case (st.ph)
      H_IDLE: begin
        if (cmd_valid) begin
          n.rdy = 1'b0;
          n.write = cmd_write;
          n.addr = cmd_addr;
          n.len = cmd_len;
          n.sel = spi_config[CFG_SEL_POL];
          n.sclk = spi_config[CFG_CPOL];
          n.edges = '0;
          n.ipos = '0;
          n.opos = '0;
          n.ph = H_SETUP;
          if (!spi_config[CFG_CPHA]) begin
            n.mosi = cmd_addr[LOW_ADDR_W-1];
            n.opos = POS_W'(1);
          end
        end
      end
      H_SETUP: begin
        if (tick) begin
          n.ok = s2[1];
          n.ph = H_RUN;
        end
      end
      H_RUN: begin
        if (tick) begin
          n.sclk = !st.sclk;
          n.edges = st.edges + 1'b1;
          lead = !st.edges[0];
          if (lead == spi_config[CFG_CPHA]) begin
            if (st.opos < total) begin
              b = tx_byte(st.opos >> BIT_W);
              n.mosi = b[~st.opos[BIT_W-1:0]];
              n.opos = st.opos + 1'b1;
              n.take = st.write && (st.opos[BIT_W-1:0] == '1) && ((st.opos >> BIT_W) >= HDR_BYTES);
            end
          end else begin
            rxb = {st.rx[BYTE_W-2:0], s2[1]};
            n.rx = rxb;
            n.ipos = st.ipos + 1'b1;
            if (st.ipos[BIT_W-1:0] == '1) begin
              if ((st.ipos >> BIT_W) < IRQ_BYTES) begin
                n.irqb[BYTE_W*st.ipos[BIT_W+1:BIT_W] +: BYTE_W] = rxb;
              end else if (!st.write && (st.ipos >> BIT_W) > HDR_BYTES) begin
                n.rvalid = 1'b1;
                n.rdata = rxb;
              end
            end
          end
          if (n.edges == {total, 1'b0}) begin
            n.ph = H_HOLD;
          end
        end
      end
      H_HOLD: begin
        if (tick) begin
          n.sel = !spi_config[CFG_SEL_POL];
          n.ph = H_GAP;
        end
      end
      H_GAP: begin
        if (tick) begin
          n.rdy = 1'b1;
          n.ph = H_IDLE;
        end
      end
    endcase
    if (st.ph == H_IDLE && !cmd_valid) begin
      n.sel = !spi_config[CFG_SEL_POL];
      n.sclk = spi_config[CFG_CPOL];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= HOST_RST;
    end else if (ce) begin
      st <= n;
    end
  end

  assign link.slave_select = st.sel;
  assign link.serial_clock = st.sclk;
  assign link.serial_data_in = st.mosi;
  assign cmd_ready = st.rdy;
  assign wr_take = st.take;
  assign rd_valid = st.rvalid;
  assign rd_data = st.rdata;
  assign irq_bytes = st.irqb;
  assign access_ok = st.ok;
  assign irq_active = st.irq;
endmodule
`default_nettype wire

// *** dv/spi_link_props.sv ***
// Property checker watching the serial link between host end and device end
`timescale 1ns/100ps
`default_nettype none
module spi_link_props (
  input wire logic clk,
  input wire logic resetn,
  input wire logic slave_select,
  input wire logic serial_clock,
  input wire logic serial_data_in,
  input wire logic serial_data_out
);
  logic sclk_q;
  logic next_sclk_q;
  logic [11:0] cnt;
  logic [11:0] next_cnt;
  logic [7:0] sh;
  logic [7:0] next_sh;

  // ==========================================================
  // Sample-edge counter
  // Falling edges are the sample edges in mode 1, the only mode the bench runs
  always_comb begin
    next_sclk_q = serial_clock;
    next_cnt = cnt;
    next_sh = sh;
    if (!slave_select) begin
      next_cnt = '0;
    end else if (sclk_q && !serial_clock) begin
      next_cnt = cnt + 12'h001;
      next_sh = {sh[6:0], serial_data_in};
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sclk_q <= 1'b0;
      cnt <= '0;
      sh <= '0;
    end else begin
      sclk_q <= next_sclk_q;
      cnt <= next_cnt;
      sh <= next_sh;
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  clk_idle_a: assert property (!slave_select |-> !serial_clock)
    else $error("Serial clock moved while deselected");
  sel_start_a: assert property ($rose(slave_select) |-> !serial_clock [*4])
    else $error("Clock edge too close to select");
  sel_gap_a: assert property ($fell(slave_select) |-> !slave_select [*8])
    else $error("Select reasserted without gap");
  byte_count_a: assert property ($fell(slave_select) |-> cnt[2:0] == 3'h0)
    else $error("Clock count not whole bytes");
  mosi_hold_a: assert property (slave_select && $fell(serial_clock) |-> $stable(serial_data_in))
    else $error("Data in changed on sample edge");
  miso_hold_a: assert property (slave_select && $fell(serial_clock) |-> $stable(serial_data_out))
    else $error("Data out changed on sample edge");
  ext_cmd_a: assert property (cnt == 12'h010 && $changed(cnt) |-> sh[2:0] == 3'h6)
    else $error("Second byte lacks extension command");
  res_bits_a: assert property (cnt == 12'h018 && $changed(cnt) |-> sh[1:0] == 2'h0)
    else $error("Reserved bits of third byte not zero");
endmodule
`default_nettype wire

// *** dv/tb_spi_slave_process_data_port.sv ***
// Self-checking bench joining host end and device end over the serial link
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("Error at %0t: got %0h expected %0h", $time, g, e); \
  end \
end
module tb_spi_slave_process_data_port;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] pdi_type = 8'h05;
  // Mode 1, select and irq active high
  logic [7:0] cfg = 8'h19;
  logic [23:0] req = 24'hC3A55A;
  logic [23:0] mask = 24'h000000;
  logic rd_ack = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic wr_ready = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [15:0] cmd_addr = 16'h0000;
  logic [7:0] cmd_len = 8'h00;
  logic [7:0] wbuf [0:7];
  logic [7:0] mem [logic [15:0]];
  logic [7:0] rq [$];
  int widx = 0;
  int ack_wait = 0;
  int errs = 0;
  int fails = 0;
  int comparisons = 0;
  logic d_rd_req, d_wr_valid, d_access_error, cmd_ready, h_wr_take, h_rd_valid, h_access_ok, h_irq_active;
  logic [15:0] d_rd_addr, d_wr_addr;
  logic [7:0] d_wr_data, d_err_count, h_rd_data;
  logic [23:0] h_irq_bytes;

  always #2.5 clk = ~clk;

  spi_link_if link();

  spi_pdi_device spi_pdi_device_inst (.clk(clk), .resetn(resetn), .ce(1'b1), .link(link),
    .process_data_interface(pdi_type), .spi_config(cfg), .application_event_request(req), .event_mask(mask),
    .rd_req(d_rd_req), .rd_addr(d_rd_addr), .rd_ack(rd_ack), .rd_data(rd_data), .wr_valid(d_wr_valid),
    .wr_ready(wr_ready), .wr_addr(d_wr_addr), .wr_data(d_wr_data), .err_count(d_err_count),
    .access_error(d_access_error));

  spi_pdi_host #(.SCLK_HALF(8)) spi_pdi_host_inst (.clk(clk), .resetn(resetn), .ce(1'b1), .link(link),
    .spi_config(cfg), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_len(cmd_len), .wr_data(wbuf[widx[2:0]]), .wr_take(h_wr_take), .rd_valid(h_rd_valid),
    .rd_data(h_rd_data), .irq_bytes(h_irq_bytes), .access_ok(h_access_ok), .irq_active(h_irq_active));

  spi_link_props spi_link_props_inst (.clk(clk), .resetn(resetn), .slave_select(link.slave_select),
    .serial_clock(link.serial_clock), .serial_data_in(link.serial_data_in),
    .serial_data_out(link.serial_data_out));

  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction

  // ==========================================================
  // Memory side of the device and host-side collectors
  // A few cycles of fetch delay keep the read path from looking instant
  always @(negedge clk) begin
    rd_ack <= 1'b0;
    if (d_rd_req && !rd_ack) begin
      if (ack_wait == 3) begin
        rd_ack <= 1'b1;
        rd_data <= pat(d_rd_addr);
        ack_wait <= 0;
      end else begin
        ack_wait <= ack_wait + 1;
      end
    end
    if (h_wr_take) widx <= widx + 1;
    if (h_rd_valid) rq.push_back(h_rd_data);
    if (d_access_error) errs <= errs + 1;
  end

  // Pops are logged at the edge that takes them, so a ready change at the
  // falling edge cannot race the log
  always @(posedge clk) begin
    if (d_wr_valid && wr_ready) mem[d_wr_addr] = d_wr_data;
  end

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic access(input logic w, input logic [15:0] a, input logic [7:0] n);
    int t;
    t = 0;
    widx = 0;
    rq.delete();
    cmd_write = w;
    cmd_addr = a;
    cmd_len = n;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    while (!cmd_ready && t < 20000) begin
      @(negedge clk);
      t++;
    end
    if (t >= 20000) begin
      fails++;
      $display("Error at %0t: command never finished", $time);
    end
  endtask

  task automatic check_read(input logic [15:0] a, input int n);
    `CHK(rq.size(), n)
    for (int i = 0; i < n; i++) `CHK(rq[i], pat(16'(a + i)))
  endtask

  initial begin
    #300000;
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    wrap_up();
  end

  initial begin
    wbuf = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88};
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    // Write across a low-byte carry in the upper 8K region
    access(1'b1, 16'hE1FE, 8'h03);
    for (int i = 0; i < 3; i++) `CHK(mem[16'(16'hE1FE + i)], wbuf[i])
    `CHK(h_irq_bytes, 24'hC3A55A)
    `CHK(h_access_ok, 1'b1)
    $display("write test done");
    access(1'b0, 16'h01FF, 8'h04);
    check_read(16'h01FF, 4);
    $display("read test done");
    mask = 24'h3C5AA5;
    repeat (8) @(negedge clk);
    `CHK(link.host_irq, 1'b0)
    mask = 24'h000002;
    repeat (8) @(negedge clk);
    `CHK(link.host_irq, 1'b1)
    `CHK(h_irq_active, 1'b1)
    $display("irq test done");
    // Fifth byte finds the FIFO full while the memory side stalls
    wr_ready = 1'b0;
    access(1'b1, 16'h0100, 8'h05);
    `CHK(errs, 1)
    `CHK(d_err_count, 8'h01)
    wr_ready = 1'b1;
    repeat (12) @(negedge clk);
    for (int i = 0; i < 4; i++) `CHK(mem[16'(16'h0100 + i)], wbuf[i])
    `CHK(mem.exists(16'h0104), 0)
    access(1'b0, 16'h0200, 8'h01);
    `CHK(h_access_ok, 1'b0)
    check_read(16'h0200, 1);
    $display("overflow test done");
    pdi_type = 8'h04;
    access(1'b1, 16'h0300, 8'h01);
    repeat (12) @(negedge clk);
    `CHK(mem.exists(16'h0300), 0)
    pdi_type = 8'h05;
    access(1'b0, 16'h0201, 8'h02);
    `CHK(h_access_ok, 1'b1)
    `CHK(d_err_count, 8'h01)
    check_read(16'h0201, 2);
    $display("inactive port test done");
    wrap_up();
  end
endmodule
`default_nettype wire
